// File: logic/rtcac_pkg.sv
package rtcac_pkg;

    // register offsets
    localparam logic [3:0] RTCAC_OFS_PERIODIC   = 4'h0;
    localparam logic [3:0] RTCAC_OFS_ADJUST     = 4'h1;
    localparam logic [3:0] RTCAC_OFS_ALM_MIN_U  = 4'h2;
    localparam logic [3:0] RTCAC_OFS_ALM_MIN_T  = 4'h3;
    localparam logic [3:0] RTCAC_OFS_ALM_HR_U   = 4'h4;
    localparam logic [3:0] RTCAC_OFS_ALM_HR_T   = 4'h5;
    localparam logic [3:0] RTCAC_OFS_HOUR_FMT   = 4'ha;
    localparam logic [3:0] RTCAC_OFS_STATUS     = 4'hd;

    // field positions
    localparam int RTCAC_BIT_MODE      = 3;
    localparam int RTCAC_BIT_ADJ       = 0;
    localparam int RTCAC_BIT_FMT       = 0;
    localparam int RTCAC_BIT_FLAG      = 0;
    localparam int RTCAC_BIT_BUSY      = 1;

    // reset values
    localparam logic [3:0] RTCAC_RST_PERIODIC = 4'h0;
    localparam logic       RTCAC_RST_FMT      = 1'b0;
    localparam logic [6:0] RTCAC_RST_MIN      = 7'h00;
    localparam logic [5:0] RTCAC_RST_HOUR_24  = 6'h00;

    // periodic rate codes
    localparam logic [2:0] RTCAC_RATE_OFF  = 3'h0;
    localparam logic [2:0] RTCAC_RATE_2048 = 3'h1;
    localparam logic [2:0] RTCAC_RATE_1024 = 3'h2;
    localparam logic [2:0] RTCAC_RATE_128  = 3'h3;
    localparam logic [2:0] RTCAC_RATE_16   = 3'h4;
    localparam logic [2:0] RTCAC_RATE_1    = 3'h5;
    localparam logic [2:0] RTCAC_RATE_MIN  = 3'h6;
    localparam logic [2:0] RTCAC_RATE_ON   = 3'h7;

    // divider chain taps, base tick 4096 Hz
    localparam int RTCAC_TAP_2048 = 0;
    localparam int RTCAC_TAP_1024 = 1;
    localparam int RTCAC_TAP_128  = 4;
    localparam int RTCAC_TAP_16   = 7;
    localparam int RTCAC_TAP_1    = 11;
    localparam int RTCAC_SUB_LO   = 8;
    localparam int RTCAC_CHAIN_W  = 12;

    // timing
    localparam int RTCAC_CLK_HZ        = 40000000;
    localparam int RTCAC_CLK_PERIOD_NS = 25;
    localparam int RTCAC_TICK_HZ       = 4096;
    localparam int RTCAC_TICK_CYCLES   = RTCAC_CLK_HZ / RTCAC_TICK_HZ;
    localparam int RTCAC_BUSY_TIME_NS  = 122100;
    localparam int RTCAC_BUSY_CYCLES   = RTCAC_BUSY_TIME_NS / RTCAC_CLK_PERIOD_NS;

    // bcd limits
    localparam logic [6:0] RTCAC_SEC_HALF = 7'h30;
    localparam logic [6:0] RTCAC_MAX_59   = 7'h59;
    localparam logic [6:0] RTCAC_MIN_HALF = 7'h30;

endpackage

// File: logic/rtcac_divider.sv
`timescale 1ns/1ps
module rtcac_divider import rtcac_pkg::*; #(
    parameter int TICK_CYCLES = RTCAC_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    // control
    input  wire logic                     i_clear_sub,
    // chain state
    output logic      [RTCAC_CHAIN_W-1:0] o_chain,
    output logic                          o_sec_tick
);

    initial begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin
            $error("rtcac_divider: TICK_CYCLES out of range");
        end
    end

    logic [15:0]              pre_ff;
    logic [RTCAC_CHAIN_W-1:0] chain_ff;
    logic                     tick;

    assign tick       = (pre_ff == 16'(TICK_CYCLES - 1));
    assign o_chain    = chain_ff;
    assign o_sec_tick = tick & (&chain_ff) & ~i_clear_sub;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pre_ff   <= 16'h0000;
            chain_ff <= '0;
        end else begin
            pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
            if (i_clear_sub) begin
                chain_ff[RTCAC_CHAIN_W-1:RTCAC_SUB_LO] <= '0;
            end else if (tick) begin
                chain_ff <= chain_ff + 1'b1;
            end
        end
    end

endmodule

// File: logic/rtcac_timekeep.sv
`timescale 1ns/1ps
module rtcac_timekeep import rtcac_pkg::*; (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // events and hour format
    input  wire logic       i_sec_tick,
    input  wire logic       i_adjust,
    input  wire logic       i_fmt_24,
    // time digits and carry
    output logic      [6:0] o_sec,
    output logic      [6:0] o_min,
    output logic      [5:0] o_hour,
    output logic            o_carry
);

    logic [6:0] sec_ff;
    logic [6:0] min_ff;
    logic [5:0] hour_ff;
    logic       carry_ff;
    logic       min_step;
    logic       hour_step;

    function automatic logic [6:0] bcd_inc(input logic [6:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {3'(v[6:4] + 3'h1), 4'h0} : {v[6:4], 4'(v[3:0] + 4'h1)};
    endfunction

    // 12h: 12,01..11 am then 32,21..31 pm
    function automatic logic [5:0] hour_inc(input logic [5:0] h, input logic f24);
        logic [5:0] r;
        r = {h[5:4], 4'(h[3:0] + 4'h1)};
        if (f24) begin
            if (h == 6'h23) r = 6'h00;
            else if (h[3:0] == 4'h9) r = {2'(h[5:4] + 2'h1), 4'h0};
        end else begin
            if (h == 6'h11) r = 6'h32;
            else if (h == 6'h31) r = 6'h12;
            else if (h == 6'h12) r = 6'h01;
            else if (h == 6'h32) r = 6'h21;
            else if (h[3:0] == 4'h9) r = {2'(h[5:4] + 2'h1), 4'h0};
        end
        return r;
    endfunction

    assign min_step  = i_adjust ? (sec_ff >= RTCAC_SEC_HALF)
                                : (i_sec_tick & (sec_ff == RTCAC_MAX_59));
    assign hour_step = min_step & (min_ff == RTCAC_MAX_59);
    assign o_sec     = sec_ff;
    assign o_min     = min_ff;
    assign o_hour    = hour_ff;
    assign o_carry   = carry_ff;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sec_ff   <= 7'h00;
            min_ff   <= RTCAC_RST_MIN;
            hour_ff  <= RTCAC_RST_HOUR_24;
            carry_ff <= 1'b0;
        end else begin
            carry_ff <= i_sec_tick | i_adjust;
            if (i_adjust) begin
                sec_ff <= 7'h00;
            end else if (i_sec_tick) begin
                sec_ff <= (sec_ff == RTCAC_MAX_59) ? 7'h00 : bcd_inc(sec_ff);
            end
            if (min_step) begin
                min_ff <= (min_ff == RTCAC_MAX_59) ? 7'h00 : bcd_inc(min_ff);
            end
            if (hour_step) begin
                hour_ff <= hour_inc(hour_ff, i_fmt_24);
            end
        end
    end

endmodule

// File: logic/rtcac_cfg.sv
//
// Function
// - adjust bit write-only, reads zero
// - adjust at 00-29: clear sub-second, seconds 00
// - adjust at 30-59: seconds 00, minute plus one
// - busy after adjust at most 122.1 us
// - interrupt select bits write-only, read zero
// - codes 000 off, 2048, 1024, 128 Hz
// - codes 16 Hz, 1 Hz, one minute
// - code 111 holds interrupt low always
// - pulse mode 50 percent, flag ignores writes
// - level mode holds until flag written zero
// - four alarm digit registers at 2h-5h
// - unused alarm bits read zero, not written
// - 12-hour code 12 midnight, 32 noon
// - format bit: 0 12-hour, 1 24-hour
// - pm hours tens raised by two
// - sub-second clear hits 8 Hz to 1 Hz
// - busy while counters carry or reset
// - flag reads one while interrupt low
//
`timescale 1ns/1ps
module rtcac_cfg import rtcac_pkg::*; #(
    parameter int TICK_CYCLES = RTCAC_TICK_CYCLES,
    parameter int BUSY_CYCLES = RTCAC_BUSY_CYCLES
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // register port
    input  wire logic [3:0] i_addr,
    input  wire logic [3:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [3:0] o_rdata,
    // interrupt pin
    output logic            o_irq_out_n,
    // status
    output logic            o_counter_busy_flag,
    output logic            o_alarm_match,
    // time digits
    output logic      [6:0] o_seconds,
    output logic      [6:0] o_minutes,
    output logic      [5:0] o_hours
);

    initial begin
        if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin
            $error("rtcac_cfg: BUSY_CYCLES out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [3:0]               periodic_sel_ff;
    logic                     fmt_24_ff;
    logic [3:0]               alm_min_u_ff;
    logic [2:0]               alm_min_t_ff;
    logic [3:0]               alm_hr_u_ff;
    logic [1:0]               alm_hr_t_ff;
    logic                     flag_ff;
    logic                     active_ff;
    logic [15:0]              busy_cnt_ff;
    logic                     busy_ff;
    logic [3:0]               rdata_ff;
    logic                     irq_n_ff;

    logic                     nxt_flag;
    logic [15:0]              nxt_busy_cnt;
    logic                     nxt_busy;
    logic [3:0]               nxt_rdata;

    logic [RTCAC_CHAIN_W-1:0] chain;
    logic                     sec_tick;
    logic                     carry;
    logic [6:0]               sec;
    logic [6:0]               min;
    logic [5:0]               hour;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic wr_periodic;
    logic wr_adjust;
    logic wr_alm_min_u;
    logic wr_alm_min_t;
    logic wr_alm_hr_u;
    logic wr_alm_hr_t;
    logic wr_fmt;
    logic wr_status;
    logic adjust;

    assign wr_periodic  = i_wr & (i_addr == RTCAC_OFS_PERIODIC);
    assign wr_adjust    = i_wr & (i_addr == RTCAC_OFS_ADJUST);
    assign wr_alm_min_u = i_wr & (i_addr == RTCAC_OFS_ALM_MIN_U);
    assign wr_alm_min_t = i_wr & (i_addr == RTCAC_OFS_ALM_MIN_T);
    assign wr_alm_hr_u  = i_wr & (i_addr == RTCAC_OFS_ALM_HR_U);
    assign wr_alm_hr_t  = i_wr & (i_addr == RTCAC_OFS_ALM_HR_T);
    assign wr_fmt       = i_wr & (i_addr == RTCAC_OFS_HOUR_FMT);
    assign wr_status    = i_wr & (i_addr == RTCAC_OFS_STATUS);

    // only bit 0 acts; upper bits of the adjust register are ignored
    assign adjust = wr_adjust & i_wdata[RTCAC_BIT_ADJ];

    ////////////////////////////////////////////////////////////////////////////
    // divider chain and time counters

    rtcac_divider #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_divider (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_clear_sub (adjust),
        .o_chain     (chain),
        .o_sec_tick  (sec_tick)
    );

    rtcac_timekeep u_timekeep (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_sec_tick (sec_tick),
        .i_adjust   (adjust),
        .i_fmt_24   (fmt_24_ff),
        .o_sec      (sec),
        .o_min      (min),
        .o_hour     (hour),
        .o_carry    (carry)
    );

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            periodic_sel_ff <= RTCAC_RST_PERIODIC;
            fmt_24_ff       <= RTCAC_RST_FMT;
        end else begin
            if (wr_periodic) begin
                periodic_sel_ff <= i_wdata;
            end
            if (wr_fmt) begin
                fmt_24_ff <= i_wdata[RTCAC_BIT_FMT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm digits

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            alm_min_u_ff <= 4'h0;
            alm_min_t_ff <= 3'h0;
            alm_hr_u_ff  <= 4'h0;
            alm_hr_t_ff  <= 2'h0;
        end else begin
            if (wr_alm_min_u) begin
                alm_min_u_ff <= i_wdata;
            end
            if (wr_alm_min_t) begin
                alm_min_t_ff <= i_wdata[2:0];
            end
            if (wr_alm_hr_u) begin
                alm_hr_u_ff <= i_wdata;
            end
            if (wr_alm_hr_t) begin
                alm_hr_t_ff <= i_wdata[1:0];
            end
        end
    end

    // same bcd hour coding for time and alarm
    assign o_alarm_match = ({alm_hr_t_ff, alm_hr_u_ff} == hour)
                         & ({alm_min_t_ff, alm_min_u_ff} == min);

    ////////////////////////////////////////////////////////////////////////////
    // busy flag

    logic busy_run;

    assign busy_run = (busy_cnt_ff != 16'h0000);

    assign nxt_busy_cnt = adjust   ? 16'(BUSY_CYCLES - 1)
                        : busy_run ? busy_cnt_ff - 16'h0001
                        : 16'h0000;

    assign nxt_busy = adjust | (busy_run & (busy_cnt_ff != 16'h0001))
                    | sec_tick | carry;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            busy_cnt_ff <= 16'h0000;
            busy_ff     <= 1'b0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
            busy_ff     <= nxt_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // periodic interrupt

    logic [2:0] rate;
    logic       level_mode;
    logic       active;
    logic       rise;
    logic       rate_on;
    logic       rate_off;
    logic       flag_clear;
    logic       irq_asserted;

    assign rate       = periodic_sel_ff[2:0];
    assign level_mode = periodic_sel_ff[RTCAC_BIT_MODE];
    assign rate_on    = (rate == RTCAC_RATE_ON);
    assign rate_off   = (rate == RTCAC_RATE_OFF);

    // active half of each period starts on the chain edge that begins it
    assign active =
          (rate == RTCAC_RATE_2048) ? ~chain[RTCAC_TAP_2048]
        : (rate == RTCAC_RATE_1024) ? ~chain[RTCAC_TAP_1024]
        : (rate == RTCAC_RATE_128)  ? ~chain[RTCAC_TAP_128]
        : (rate == RTCAC_RATE_16)   ? ~chain[RTCAC_TAP_16]
        : (rate == RTCAC_RATE_1)    ? ~chain[RTCAC_TAP_1]
        : (rate == RTCAC_RATE_MIN)  ? (sec < RTCAC_MIN_HALF)
        : 1'b0;

    assign rise = active & ~active_ff;

    // writes to the flag only count in level mode, and only a zero clears
    assign flag_clear = wr_status & level_mode
                      & ~i_wdata[RTCAC_BIT_FLAG];

    // a new edge wins over a clear in the same cycle
    assign nxt_flag = (level_mode & ~rate_off & rise) ? 1'b1
                    : flag_clear ? 1'b0
                    : (level_mode ? flag_ff : 1'b0);

    assign irq_asserted = rate_on
                        | (~rate_off & (level_mode ? flag_ff : active));

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            active_ff <= 1'b0;
            flag_ff   <= 1'b0;
            irq_n_ff  <= 1'b1;
        end else begin
            active_ff <= active;
            flag_ff   <= nxt_flag;
            irq_n_ff  <= ~irq_asserted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    logic [3:0] rd_status;
    logic [3:0] rd_mux;

    assign rd_status = {2'b00, busy_ff, ~irq_n_ff};

    assign rd_mux =
          (i_addr == RTCAC_OFS_PERIODIC)  ? 4'h0
        : (i_addr == RTCAC_OFS_ADJUST)    ? 4'h0
        : (i_addr == RTCAC_OFS_ALM_MIN_U) ? alm_min_u_ff
        : (i_addr == RTCAC_OFS_ALM_MIN_T) ? {1'b0, alm_min_t_ff}
        : (i_addr == RTCAC_OFS_ALM_HR_U)  ? alm_hr_u_ff
        : (i_addr == RTCAC_OFS_ALM_HR_T)  ? {2'b00, alm_hr_t_ff}
        : (i_addr == RTCAC_OFS_HOUR_FMT)  ? 4'h0
        : (i_addr == RTCAC_OFS_STATUS)    ? rd_status
        : 4'h0;

    assign nxt_rdata = i_rd ? rd_mux : 4'h0;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= 4'h0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_rdata             = rdata_ff;
    assign o_irq_out_n         = irq_n_ff;
    assign o_counter_busy_flag = busy_ff;
    assign o_seconds           = sec;
    assign o_minutes           = min;
    assign o_hours             = hour;

endmodule

// File: testbench/rtcac_cfg_asserts.sv
`timescale 1ns/1ps
module rtcac_cfg_asserts import rtcac_pkg::*; #(
    parameter int BUSY_CYCLES = RTCAC_BUSY_CYCLES
) (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [3:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [3:0] o_rdata,
    // pins and status
    input wire logic       o_irq_out_n,
    input wire logic       o_counter_busy_flag,
    input wire logic       o_alarm_match,
    input wire logic [6:0] o_seconds,
    input wire logic [6:0] o_minutes,
    input wire logic [5:0] o_hours
);
    ////////////////////////////////////////////////////////////////
    logic        adj_wr;
    logic        sel_wr;
    logic        wo_rd;
    logic [15:0] busy_cnt_ff;
    assign adj_wr = i_wr && i_addr == RTCAC_OFS_ADJUST && i_wdata[RTCAC_BIT_ADJ];
    assign sel_wr = i_wr && i_addr == RTCAC_OFS_PERIODIC;
    assign wo_rd  = i_rd && (i_addr == RTCAC_OFS_PERIODIC || i_addr == RTCAC_OFS_ADJUST
                    || i_addr == RTCAC_OFS_HOUR_FMT);
    // consecutive busy cycles
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) busy_cnt_ff <= 16'h0000;
        else busy_cnt_ff <= o_counter_busy_flag ? busy_cnt_ff + 16'h0001 : 16'h0000;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 4'h0)
        else $error("read data not zero outside answer cycle");
    a_wo_read_zero: assert property (wo_rd |=> o_rdata == 4'h0)
        else $error("write-only register read not zero");
    a_alarm_unused: assert property (i_rd && i_addr == RTCAC_OFS_ALM_MIN_T |=>
        !o_rdata[3])
        else $error("alarm minute tens bit3 not zero");
    a_alarm_hr_unused: assert property (i_rd && i_addr == RTCAC_OFS_ALM_HR_T |=>
        o_rdata[3:2] == 2'h0)
        else $error("alarm hour tens upper bits not zero");
    a_adjust_seconds: assert property (adj_wr |=> o_seconds == 7'h00)
        else $error("seconds not 00 after adjust");
    a_adjust_minutes: assert property (adj_wr |=>
        ($past(o_seconds) < RTCAC_SEC_HALF) ? $stable(o_minutes) : o_minutes != $past(o_minutes))
        else $error("minutes wrong after adjust");
    a_adjust_busy: assert property (adj_wr |=> o_counter_busy_flag[*3])
        else $error("busy not raised by adjust");
    a_busy_bound: assert property (busy_cnt_ff <= BUSY_CYCLES + 3)
        else $error("busy held too long");
    a_busy_status: assert property (i_rd && i_addr == RTCAC_OFS_STATUS |=>
        o_rdata[RTCAC_BIT_BUSY] == $past(o_counter_busy_flag))
        else $error("status busy bit differs from busy pin");
    a_irq_on_code: assert property (sel_wr && i_wdata[2:0] == RTCAC_RATE_ON |->
        ##3 !o_irq_out_n)
        else $error("interrupt not low for code 7");
    a_irq_off_code: assert property (sel_wr && i_wdata[2:0] == RTCAC_RATE_OFF |->
        ##3 o_irq_out_n[*4])
        else $error("interrupt not released for code 0");
    c_adjust: cover property (adj_wr);
    c_irq_fall: cover property ($fell(o_irq_out_n));
    c_flag_clear: cover property (i_wr && i_addr == RTCAC_OFS_STATUS);
endmodule

// File: testbench/rtcac_host_model.sv
`timescale 1ns/1ps
module rtcac_host_model (
    // clock and read data
    input  wire logic       i_clk,
    input  wire logic [3:0] i_rdata,
    // register port
    output logic      [3:0] o_addr,
    output logic      [3:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr  = 4'h0;
        o_wdata = 4'h0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // one-cycle write, lines inverted after release
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask
    // one-cycle read, data in following cycle
    task automatic rd(input logic [3:0] a, output logic [3:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb import rtcac_pkg::*;;
    localparam int TICK_CYC = 4;
    localparam int BUSY_CYC = 8;
    logic       i_clk;
    logic       i_reset;
    logic [3:0] i_addr;
    logic [3:0] i_wdata;
    logic       i_wr;
    logic       i_rd;
    logic [3:0] o_rdata;
    logic       o_irq_out_n;
    logic       o_counter_busy_flag;
    logic       o_alarm_match;
    logic [6:0] o_seconds;
    logic [6:0] o_minutes;
    logic [5:0] o_hours;
    int         mismatches;
    int         tests_run;
    ////////////////////////////////////////////////////////////////
    rtcac_host_model u_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
    rtcac_cfg #(.TICK_CYCLES(TICK_CYC), .BUSY_CYCLES(BUSY_CYC)) uut (.i_clk(i_clk),
        .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq_out_n(o_irq_out_n),
        .o_counter_busy_flag(o_counter_busy_flag), .o_alarm_match(o_alarm_match),
        .o_seconds(o_seconds), .o_minutes(o_minutes), .o_hours(o_hours));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic rd_check(input string name, input logic [3:0] a, input logic [3:0] exp);
        logic [3:0] d;
        u_host.rd(a, d);
        check(name, {28'h0, d}, {28'h0, exp});
    endtask
    task automatic wait_fall(input int lim);
        int n;
        n = 0;
        tick(2);
        while (o_irq_out_n !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        while (o_irq_out_n !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        check("irq fall", {31'h0, o_irq_out_n}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset_map();
        for (int a = 0; a < 16; a++) begin
            rd_check("reset read", 4'(a), 4'h0);
        end
    endtask
    task automatic t_alarm();
        logic [3:0] alm [4];
        alm = '{4'h9, 4'h5, 4'h1, 4'h3};
        u_host.wr(RTCAC_OFS_HOUR_FMT, 4'h0);
        u_host.wr(RTCAC_OFS_ALM_MIN_T, 4'hd);
        rd_check("alarm min tens", RTCAC_OFS_ALM_MIN_T, 4'h5);
        u_host.wr(RTCAC_OFS_ALM_HR_T, 4'hf);
        rd_check("alarm hr tens", RTCAC_OFS_ALM_HR_T, 4'h3);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(RTCAC_OFS_ALM_MIN_U + 4'(i), alm[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_check("alarm", RTCAC_OFS_ALM_MIN_U + 4'(i), alm[i]);
        end
        check("alarm match", {31'h0, o_alarm_match}, 32'h0);
        u_host.wr(RTCAC_OFS_HOUR_FMT, 4'h1);
        rd_check("format", RTCAC_OFS_HOUR_FMT, 4'h0);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(RTCAC_OFS_ALM_MIN_U + 4'(i), 4'h0);
        end
        tick(1);
        check("alarm match", {31'h0, o_alarm_match}, 32'h1);
    endtask
    task automatic t_adjust();
        int n;
        n = 0;
        while (o_seconds !== 7'h01 && n < 20000) begin
            tick(1);
            n++;
        end
        tick(8000);
        u_host.wr(RTCAC_OFS_ADJUST, 4'hf);
        tick(1);
        check("adjust seconds", {25'h0, o_seconds}, 32'h0);
        check("adjust minutes", {25'h0, o_minutes}, 32'h0);
        check("adjust hours", {26'h0, o_hours}, 32'h0);
        check("adjust busy", {31'h0, o_counter_busy_flag}, 32'h1);
        tick(BUSY_CYC + 2);
        check("busy end", {31'h0, o_counter_busy_flag}, 32'h0);
        rd_check("adjust read", RTCAC_OFS_ADJUST, 4'h0);
        tick(15000);
        check("restart seconds", {25'h0, o_seconds}, 32'h0);
        tick(2000);
        check("next second", {25'h0, o_seconds}, 32'h1);
    endtask
    task automatic t_rates();
        logic [2:0] code [5];
        int         hz [5];
        int         half;
        int         lo;
        int         hi;
        code = '{RTCAC_RATE_2048, RTCAC_RATE_1024, RTCAC_RATE_128, RTCAC_RATE_16, RTCAC_RATE_1};
        hz = '{2048, 1024, 128, 16, 1};
        for (int i = 0; i < 5; i++) begin
            half = TICK_CYC * 2048 / hz[i];
            u_host.wr(RTCAC_OFS_PERIODIC, {1'b0, code[i]});
            wait_fall(4 * half);
            lo = 0;
            hi = 0;
            while (o_irq_out_n === 1'b0 && lo < 4 * half) begin
                tick(1);
                lo++;
            end
            while (o_irq_out_n === 1'b1 && hi < 4 * half) begin
                tick(1);
                hi++;
            end
            check("low time", lo, half);
            check("high time", hi, half);
        end
    endtask
    task automatic t_modes();
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b0, RTCAC_RATE_16});
        wait_fall(2100);
        u_host.wr(RTCAC_OFS_STATUS, 4'h0);
        tick(2);
        check("pulse flag write", {31'h0, o_irq_out_n}, 32'h0);
        rd_check("pulse flag", RTCAC_OFS_STATUS, 4'h1);
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b0, RTCAC_RATE_ON});
        tick(3);
        check("fixed low", {31'h0, o_irq_out_n}, 32'h0);
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b1, RTCAC_RATE_ON});
        tick(3);
        check("fixed low level", {31'h0, o_irq_out_n}, 32'h0);
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b1, RTCAC_RATE_16});
        u_host.wr(RTCAC_OFS_STATUS, 4'h0);
        wait_fall(2100);
        tick(700);
        check("level held", {31'h0, o_irq_out_n}, 32'h0);
        rd_check("flag set", RTCAC_OFS_STATUS, 4'h1);
        u_host.wr(RTCAC_OFS_STATUS, 4'h0);
        tick(2);
        check("level cleared", {31'h0, o_irq_out_n}, 32'h1);
        rd_check("flag clear", RTCAC_OFS_STATUS, 4'h0);
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b0, RTCAC_RATE_OFF});
        tick(10);
        check("off", {31'h0, o_irq_out_n}, 32'h1);
        u_host.wr(RTCAC_OFS_PERIODIC, {1'b0, RTCAC_RATE_MIN});
        tick(3);
        check("minute low", {31'h0, o_irq_out_n}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        mismatches = 0;
        tests_run = 0;
        i_reset = 1'b1;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        tick(1);
        t_reset_map();
        t_alarm();
        t_adjust();
        t_rates();
        t_modes();
        tally_and_finish();
    end
endmodule
bind rtcac_cfg rtcac_cfg_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq_out_n(o_irq_out_n),
    .o_counter_busy_flag(o_counter_busy_flag), .o_alarm_match(o_alarm_match),
    .o_seconds(o_seconds), .o_minutes(o_minutes), .o_hours(o_hours));
